// [rtl/wei_pkg.sv]
// wake event indicator: shared register map, field positions, codes and timing
// assumes a single 250 MHz clock shared by both ends
package wei_pkg;
   localparam int         WEI_AW = 8;
   localparam int         WEI_DW = 32;
   localparam logic [7:0] WEI_OFS_PWC       = 8'h84;
   localparam logic [7:0] WEI_OFS_BYTE_TEST = 8'hA0;
   localparam logic [7:0] WEI_OFS_HARDWARE_CONFIG_REG    = 8'hA4;

   localparam int WEI_B_READY    = 0;
   localparam int WEI_B_OUT_EN   = 1;
   localparam int WEI_B_POL      = 2;
   localparam int WEI_B_PULSE    = 3;
   localparam int WEI_B_CAUSE_ED = 4;
   localparam int WEI_B_CAUSE_LW = 5;
   localparam int WEI_B_TYPE     = 6;
   localparam int WEI_B_ENERGY_DETECT_ENABLE    = 8;
   localparam int WEI_B_LAN_WAKE_ENABLE   = 9;
   localparam int WEI_B_MODE_LO  = 12;
   localparam int WEI_B_MODE_HI  = 13;

   localparam logic [1:0] WEI_CAUSE_NONE   = 2'h0;
   localparam logic [1:0] WEI_CAUSE_ENERGY = 2'h1;
   localparam logic [1:0] WEI_CAUSE_FRAME  = 2'h2;
   localparam logic [1:0] WEI_CAUSE_MULTI  = 2'h3;

   localparam logic [1:0] WEI_MODE_FULL   = 2'h0;
   localparam logic [1:0] WEI_MODE_FRAME  = 2'h1;
   localparam logic [1:0] WEI_MODE_ENERGY = 2'h2;
   localparam logic [1:0] WEI_MODE_RSVD   = 2'h3;

   localparam logic [31:0] WEI_WORD_ZERO = 32'h0;

   localparam int WEI_CLK_KHZ       = 250000;
   localparam int WEI_PULSE_MS      = 50;
   localparam int WEI_PULSE_CYCLES  = WEI_PULSE_MS * WEI_CLK_KHZ;
   localparam int WEI_SETTLE_CYCLES = 16;

   typedef enum logic [1:0]
   {
      WEI_PW_SETTLE = 2'h0,
      WEI_PW_ON     = 2'h1,
      WEI_PW_LOW    = 2'h3
   } wei_pw_e;

   typedef enum logic [1:0]
   {
      WEI_H_IDLE   = 2'h0,
      WEI_H_STROBE = 2'h1,
      WEI_H_WAIT   = 2'h3
   } wei_hst_e;
endpackage

// [rtl/wei_if.sv]
// wake event indicator: register port and wake pin between device and host
// assumes one clock; the wake pin has a pull-up resolved here
`timescale 1ns/1ps
interface wei_if;
   import wei_pkg::*;
   logic [WEI_AW-1:0] addr;
   logic              wr;
   logic              rd;
   logic [WEI_DW-1:0] wdata;
   logic [WEI_DW-1:0] rdata;
   logic              rvalid;
   logic              wake_out;
   logic              wake_oe;
   logic              wake_line;

   // released line floats high through the pull-up
   assign wake_line = wake_oe ? wake_out : 1'h1;

   modport device
   (
      input  addr,
      input  wr,
      input  rd,
      input  wdata,
      output rdata,
      output rvalid,
      output wake_out,
      output wake_oe
   );
   modport host
   (
      output addr,
      output wr,
      output rd,
      output wdata,
      input  rdata,
      input  rvalid,
      input  wake_line
   );
endinterface

// [rtl/wei_device.sv]
// wake event indicator, device end: power/wake control register, cause
// latching, wake pin driver and internal wake interrupt
// assumes event inputs are synchronous levels held until their source clears
//
// Summary of operation
// (RULE_01) lan wake event drives pin and interrupt
// (RULE_02) energy event drives pin and interrupt
// (RULE_03) driver type: clear open-drain, set push-pull
// (RULE_04) open-drain ignores polarity, always active low
// (RULE_05) cause field: 00 none, 01 energy, 10 frame, 11 both
// (RULE_06) cause bits clear by writing one when ready
// (RULE_07) no clear while event source still active
// (RULE_08) pulse mode: pin active for 50 ms
// (RULE_09) static mode: pin held active after event
// (RULE_10) clearing cause or enable releases the pin
// (RULE_11) push-pull polarity: set high, clear low
// (RULE_12) output enable gates pin only, not interrupt
// (RULE_13) ready flag set after settling, always readable
// (RULE_14) host accesses only this register before ready; the host also passes config reads and byte test writes
// (RULE_15) host reads only config and this before ready
// (RULE_16) power mode field: full, frame, energy, reserved
// (RULE_17) byte test write wakes from reduced power
// (RULE_18) each enabled event sets its own cause bit
`timescale 1ns/1ps
module wei_device
   import wei_pkg::*;
#(
   parameter int PULSE_CYCLES  = WEI_PULSE_CYCLES,
   parameter int SETTLE_CYCLES = WEI_SETTLE_CYCLES
)
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_nrst,
   wei_if.device           bus,
   input  wire logic       i_lan_wake_event,
   input  wire logic       i_energy_event,
   output logic            o_wake_interrupt,
   output logic            o_ready,
   output logic [1:0]      o_power_state
);
   localparam int PW = $clog2(PULSE_CYCLES + 1);
   localparam int SW = $clog2(SETTLE_CYCLES + 1);

   logic          lan_wake_enable;
   logic          energy_detect_enable;
   logic          wake_out_driver_type;
   logic          wake_out_pulse_mode;
   logic          wake_out_polarity;
   logic          wake_out_enable;
   logic [1:0]    wake_cause;
   logic [1:0]    power_state_select;
   wei_pw_e       pw_state;
   logic [SW-1:0] settle_cnt;
   logic [PW-1:0] pulse_cnt;
   logic [1:0]    next_wake_cause;
   logic          wr_pwc;
   logic          wr_byte_test;
   logic          ready;
   logic          lan_hit;
   logic          ed_hit;
   logic          new_event;
   logic          armed;
   logic          wake_act;
   logic          clr_ok;
   logic [1:0]    mode_wr;
   logic [31:0]   pwc_image;

   assign wr_pwc       = bus.wr && (bus.addr == WEI_OFS_PWC);
   assign wr_byte_test = bus.wr && (bus.addr == WEI_OFS_BYTE_TEST);
   assign ready        = (pw_state == WEI_PW_ON);
   assign mode_wr      = bus.wdata[WEI_B_MODE_HI:WEI_B_MODE_LO];

   // host-writable configuration
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
      begin
         lan_wake_enable      <= 1'h0;
         energy_detect_enable <= 1'h0;
         wake_out_driver_type <= 1'h0;
         wake_out_pulse_mode  <= 1'h0;
         wake_out_polarity    <= 1'h0;
         wake_out_enable      <= 1'h0;
      end
      else if (wr_pwc)
      begin
         lan_wake_enable      <= bus.wdata[WEI_B_LAN_WAKE_ENABLE];
         energy_detect_enable <= bus.wdata[WEI_B_ENERGY_DETECT_ENABLE];
         wake_out_driver_type <= bus.wdata[WEI_B_TYPE];
         wake_out_pulse_mode  <= bus.wdata[WEI_B_PULSE];
         wake_out_polarity    <= bus.wdata[WEI_B_POL];
         wake_out_enable      <= bus.wdata[WEI_B_OUT_EN];
      end
   end

   // power state: settle after reset or wake, then ready
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
      begin
         pw_state           <= WEI_PW_SETTLE;
         settle_cnt         <= '0;
         power_state_select <= WEI_MODE_FULL;
      end
      else
      begin
         case (pw_state)
            WEI_PW_SETTLE:
            begin
               if (settle_cnt == SW'(SETTLE_CYCLES - 1))
                  pw_state <= WEI_PW_ON; // [RULE_13]
               else
                  settle_cnt <= settle_cnt + SW'(1);
            end
            WEI_PW_ON:
            begin
               // reserved code is refused and the mode stays full
               if (wr_pwc && (mode_wr == WEI_MODE_FRAME || mode_wr == WEI_MODE_ENERGY))
               begin
                  power_state_select <= mode_wr; // [RULE_16]
                  pw_state           <= WEI_PW_LOW;
               end
            end
            WEI_PW_LOW:
            begin
               if (wr_byte_test)
               begin
                  power_state_select <= WEI_MODE_FULL; // [RULE_17]
                  settle_cnt         <= '0;
                  pw_state           <= WEI_PW_SETTLE;
               end
            end
            default:
               pw_state <= WEI_PW_SETTLE;
         endcase
      end
   end

   // cause latching; a new event wins over a same-cycle clear
   assign lan_hit = i_lan_wake_event && lan_wake_enable;  // [RULE_01]
   assign ed_hit  = i_energy_event && energy_detect_enable; // [RULE_02]
   assign clr_ok  = wr_pwc && ready && (power_state_select == WEI_MODE_FULL); // [RULE_06]

   always_comb
   begin
      next_wake_cause = wake_cause;
      // source must be gone before its bit may clear
      if (clr_ok && bus.wdata[WEI_B_CAUSE_ED] && !i_energy_event) // [RULE_07]
         next_wake_cause[0] = 1'h0;
      if (clr_ok && bus.wdata[WEI_B_CAUSE_LW] && !i_lan_wake_event) // [RULE_07]
         next_wake_cause[1] = 1'h0;
      // bit 0 energy, bit 1 frame, both give the multiple code
      if (ed_hit)
         next_wake_cause[0] = 1'h1; // [RULE_18] [RULE_05]
      if (lan_hit)
         next_wake_cause[1] = 1'h1; // [RULE_18] [RULE_05]
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
         wake_cause <= WEI_CAUSE_NONE;
      else
         wake_cause <= next_wake_cause;
   end

   // pulse timer restarts on each newly latched cause
   assign new_event = (ed_hit && !wake_cause[0]) || (lan_hit && !wake_cause[1]);

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
         pulse_cnt <= '0;
      else if (new_event)
         pulse_cnt <= PW'(PULSE_CYCLES); // [RULE_08]
      else if (pulse_cnt != '0)
         pulse_cnt <= pulse_cnt - PW'(1);
   end

   assign armed    = (wake_cause[0] && energy_detect_enable)
                  || (wake_cause[1] && lan_wake_enable); // [RULE_10]
   assign wake_act = armed && wake_out_enable // [RULE_12]
                  && (!wake_out_pulse_mode || (pulse_cnt != '0)); // [RULE_08] [RULE_09]

   // pin driver and interrupt
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
      begin
         bus.wake_out     <= 1'h0;
         bus.wake_oe      <= 1'h0;
         o_wake_interrupt <= 1'h0;
      end
      else
      begin
         o_wake_interrupt <= armed; // [RULE_01] [RULE_02] [RULE_12]
         if (wake_out_driver_type)
         begin
            bus.wake_oe  <= 1'h1; // [RULE_03]
            bus.wake_out <= wake_out_polarity ? wake_act : !wake_act; // [RULE_11]
         end
         else
         begin
            bus.wake_oe  <= wake_act; // [RULE_03]
            bus.wake_out <= 1'h0; // [RULE_04]
         end
      end
   end

   always_comb
   begin
      pwc_image                               = WEI_WORD_ZERO;
      pwc_image[WEI_B_MODE_HI:WEI_B_MODE_LO]  = power_state_select;
      pwc_image[WEI_B_LAN_WAKE_ENABLE]                 = lan_wake_enable;
      pwc_image[WEI_B_ENERGY_DETECT_ENABLE]                  = energy_detect_enable;
      pwc_image[WEI_B_TYPE]                   = wake_out_driver_type;
      pwc_image[WEI_B_CAUSE_LW:WEI_B_CAUSE_ED] = wake_cause; // [RULE_05]
      pwc_image[WEI_B_PULSE]                  = wake_out_pulse_mode;
      pwc_image[WEI_B_POL]                    = wake_out_polarity;
      pwc_image[WEI_B_OUT_EN]                 = wake_out_enable;
      pwc_image[WEI_B_READY]                  = ready;
   end

   // reads answer one cycle later in every power state
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
      begin
         bus.rvalid    <= 1'h0;
         bus.rdata     <= WEI_WORD_ZERO;
         o_ready       <= 1'h0;
         o_power_state <= WEI_MODE_FULL;
      end
      else
      begin
         bus.rvalid    <= bus.rd;
         o_ready       <= ready;
         o_power_state <= power_state_select;
         if (bus.rd && bus.addr == WEI_OFS_PWC)
            bus.rdata <= pwc_image; // [RULE_13]
         else if (bus.rd)
            bus.rdata <= WEI_WORD_ZERO;
      end
   end
endmodule

// [rtl/wei_host.sv]
// wake event indicator, host end: issues register accesses for its user and
// holds back accesses the device cannot take before it reports ready
// assumes the device answers reads one cycle after the strobe
`timescale 1ns/1ps
module wei_host
   import wei_pkg::*;
(
   input  wire logic              i_sys_clk,
   input  wire logic              i_nrst,
   wei_if.host                    bus,
   input  wire logic              i_req,
   input  wire logic              i_write,
   input  wire logic [WEI_AW-1:0] i_addr,
   input  wire logic [WEI_DW-1:0] i_wdata,
   output logic                   o_busy,
   output logic                   o_done,
   output logic                   o_refused,
   output logic [WEI_DW-1:0]      o_rdata,
   output logic                   o_dev_ready,
   output logic                   o_wake_line
);
   wei_hst_e   h_state;
   logic       h_write;
   logic       allowed;
   logic [1:0] mode_req;

   // before ready only the control register, config reads and the wake write
   assign allowed = o_dev_ready || (i_addr == WEI_OFS_PWC) // [RULE_14]
                 || (!i_write && i_addr == WEI_OFS_HARDWARE_CONFIG_REG) // [RULE_15]
                 || (i_write && i_addr == WEI_OFS_BYTE_TEST);
   assign mode_req = bus.wdata[WEI_B_MODE_HI:WEI_B_MODE_LO];

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
      begin
         h_state     <= WEI_H_IDLE;
         h_write     <= 1'h0;
         bus.addr    <= '0;
         bus.wdata   <= WEI_WORD_ZERO;
         bus.wr      <= 1'h0;
         bus.rd      <= 1'h0;
         o_busy      <= 1'h0;
         o_done      <= 1'h0;
         o_refused   <= 1'h0;
         o_rdata     <= WEI_WORD_ZERO;
         o_dev_ready <= 1'h0;
      end
      else
      begin
         o_done    <= 1'h0;
         o_refused <= 1'h0;
         case (h_state)
            WEI_H_IDLE:
            begin
               if (i_req && !allowed)
                  o_refused <= 1'h1; // [RULE_14] [RULE_15]
               else if (i_req)
               begin
                  bus.addr  <= i_addr;
                  bus.wdata <= i_wdata;
                  bus.wr    <= i_write;
                  bus.rd    <= !i_write;
                  h_write   <= i_write;
                  o_busy    <= 1'h1;
                  h_state   <= WEI_H_STROBE;
               end
            end
            WEI_H_STROBE:
            begin
               bus.wr <= 1'h0;
               bus.rd <= 1'h0;
               if (h_write)
               begin
                  o_done  <= 1'h1;
                  o_busy  <= 1'h0;
                  h_state <= WEI_H_IDLE;
                  // entering reduced power drops ready until read back
                  if (bus.addr == WEI_OFS_PWC && o_dev_ready
                      && (mode_req == WEI_MODE_FRAME || mode_req == WEI_MODE_ENERGY))
                     o_dev_ready <= 1'h0;
               end
               else
                  h_state <= WEI_H_WAIT;
            end
            WEI_H_WAIT:
            begin
               if (bus.rvalid)
               begin
                  o_rdata <= bus.rdata;
                  o_done  <= 1'h1;
                  o_busy  <= 1'h0;
                  h_state <= WEI_H_IDLE;
                  if (bus.addr == WEI_OFS_PWC)
                     o_dev_ready <= bus.rdata[WEI_B_READY]; // [RULE_13]
               end
            end
            default:
               h_state <= WEI_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
         o_wake_line <= 1'h1;
      else
         o_wake_line <= bus.wake_line;
   end
endmodule

// [tb/wei_monitor.sv]
// wake event indicator: concurrent checks on the wires joining device and host
// assumes it is instantiated beside the interface with the same pulse length
`timescale 1ns/1ps
module wei_monitor
   import wei_pkg::*;
#(
   parameter int PULSE_CYCLES = WEI_PULSE_CYCLES
)
(
   input wire logic              i_sys_clk,
   input wire logic              i_nrst,
   input wire logic [WEI_AW-1:0] addr,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [WEI_DW-1:0] wdata,
   input wire logic [WEI_DW-1:0] rdata,
   input wire logic              rvalid,
   input wire logic              wake_out,
   input wire logic              wake_oe,
   input wire logic              wake_line
);
   logic [9:0] cfg;
   logic [9:0] cfg_d;
   logic [9:0] cfg_dd;
   logic       still;
   logic       act;
   logic       rdy;
   logic [7:0] rd_addr;
   int         run;

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_nrst);

   assign still = (cfg == cfg_d) && (cfg_d == cfg_dd);
   assign act   = cfg[6] ? (wake_out == cfg[2]) : (wake_oe && !wake_out);

   // shadow of the control bits last written
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
         cfg <= '0;
      else if (wr && addr == WEI_OFS_PWC)
         cfg <= wdata[9:0];
      cfg_d  <= cfg;
      cfg_dd <= cfg_d;
   end

   // host view of ready, taken from control reads
   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst)
         rdy <= 1'h0;
      else if (rvalid && rd_addr == WEI_OFS_PWC)
         rdy <= rdata[0];
      else if (wr && addr == WEI_OFS_PWC && wdata[13:12] inside {2'h1, 2'h2})
         rdy <= 1'h0;
      if (rd)
         rd_addr <= addr;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (!i_nrst || !act)
         run <= 0;
      else
         run <= run + 1;
   end

   AST_READ_ANSWER: assert property (rd |=> rvalid ##1 !rvalid)
      else $error("read strobe not answered in one cycle");
   AST_WRITE_GATE: assert property (wr && !rdy |-> addr inside {8'h84, 8'hA0})
      else $error("write issued before ready");
   AST_READ_GATE: assert property (rd && !rdy |-> addr inside {8'h84, 8'hA4})
      else $error("forbidden read before ready");
   AST_OPEN_DRAIN_LOW: assert property (still && !cfg[6] && wake_oe |-> !wake_out)
      else $error("open drain pin driven high");
   AST_PUSH_PULL_DRIVE: assert property (still && cfg[6] |-> wake_oe)
      else $error("push pull pin released");
   AST_STATIC_ACTIVE: assert property (rvalid && rdata[6] && rdata[1] && !rdata[3]
      && |(rdata[5:4] & rdata[9:8]) |-> wake_out == rdata[2])
      else $error("static pin not active");
   AST_GATE_OFF: assert property (rvalid && !rdata[1]
      |-> wake_line == (rdata[6] ? !rdata[2] : 1'h1))
      else $error("disabled pin not idle");
   AST_IDLE_RELEASED: assert property (rvalid && rdata[5:4] == 2'h0
      |-> (rdata[6] ? wake_out == !rdata[2] : !wake_oe))
      else $error("pin active with no cause");
   AST_PULSE_BOUND: assert property (still && cfg[3] |-> run <= PULSE_CYCLES)
      else $error("pulse longer than its length");

   cover property (rvalid && rdata[0]);
   cover property (cfg[3] && run == PULSE_CYCLES);
   cover property (wr && !rdy);
endmodule

// [tb/wake_event_indicator_tb.sv]
// wake event indicator: self-checking bench driving the host user side
// assumes the host end and the device end meet in one interface instance
`timescale 1ns/1ps
module wake_event_indicator_tb;
   import wei_pkg::*;
   localparam int PULSE = 20;
   logic              i_sys_clk;
   logic              i_nrst;
   logic              req;
   logic              write;
   logic [WEI_AW-1:0] addr;
   logic [WEI_DW-1:0] wdata;
   logic [WEI_DW-1:0] rdata;
   logic [WEI_DW-1:0] rdv;
   logic [1:0]        ev;
   logic [1:0]        pstate;
   logic              busy;
   logic              done;
   logic              refused;
   logic              refd;
   logic              dev_ready;
   logic              wline;
   logic              intr;
   logic              ready;
   int                errors;
   int                samples_checked;
   int                n;

   wei_if wei_if_inst ();
   wei_device #(.PULSE_CYCLES(PULSE)) wei_device_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
      .bus(wei_if_inst), .i_lan_wake_event(ev[1]), .i_energy_event(ev[0]),
      .o_wake_interrupt(intr), .o_ready(ready), .o_power_state(pstate));
   wei_host wei_host_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .bus(wei_if_inst),
      .i_req(req), .i_write(write), .i_addr(addr), .i_wdata(wdata), .o_busy(busy),
      .o_done(done), .o_refused(refused), .o_rdata(rdata), .o_dev_ready(dev_ready),
      .o_wake_line(wline));
   wei_monitor #(.PULSE_CYCLES(PULSE)) wei_monitor_inst (.i_sys_clk(i_sys_clk),
      .i_nrst(i_nrst), .addr(wei_if_inst.addr), .wr(wei_if_inst.wr), .rd(wei_if_inst.rd),
      .wdata(wei_if_inst.wdata), .rdata(wei_if_inst.rdata), .rvalid(wei_if_inst.rvalid),
      .wake_out(wei_if_inst.wake_out), .wake_oe(wei_if_inst.wake_oe),
      .wake_line(wei_if_inst.wake_line));

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one host access, then a few cycles for the pin to settle
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(negedge i_sys_clk);
      req = 1'h1;
      write = w;
      addr = a;
      wdata = d;
      @(negedge i_sys_clk);
      req = 1'h0;
      n = 0;
      while (done !== 1'h1 && refused !== 1'h1 && n < 20)
      begin
         @(negedge i_sys_clk);
         n++;
      end
      chk("reply", 32'h1, {31'h0, n < 20});
      chk("busy", 32'h0, {31'h0, busy});
      refd = refused;
      rdv = rdata;
      repeat (3) @(negedge i_sys_clk);
   endtask

   task automatic fire(input logic [1:0] m);
      @(negedge i_sys_clk);
      ev = m;
      @(negedge i_sys_clk);
      ev = 2'h0;
      repeat (4) @(negedge i_sys_clk);
   endtask

   task automatic wait_ready();
      rdv = '0;
      for (int k = 0; k < 30 && rdv[0] !== 1'h1; k++)
         acc(1'h0, WEI_OFS_PWC, '0);
      chk("ready", 32'h1, {31'h0, rdv[0]});
   endtask

   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      i_sys_clk = 1'h0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end

   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      errors++;
      $display("[FAIL] watchdog expected finish seen timeout");
      summarize();
   end

   initial
   begin
      errors = 0;
      samples_checked = 0;
      {req, write, addr, wdata, ev} = '0;
      i_nrst = 1'h0;
      repeat (20) @(negedge i_sys_clk);
      i_nrst = 1'h1;
      acc(1'h0, WEI_OFS_PWC, '0);
      chk("control reset", 32'h0, rdv & 32'hFFFFFFFE);
      chk("line idle", 32'h1, {31'h0, wline});
      chk("ready low", 32'h0, {31'h0, ready});
      acc(1'h1, 8'h88, 32'h5);
      chk("early write", 32'h1, {31'h0, refd});
      acc(1'h0, 8'h7C, '0);
      chk("early read", 32'h1, {31'h0, refd});
      acc(1'h0, WEI_OFS_HARDWARE_CONFIG_REG, '0);
      chk("config read", 32'h0, {31'h0, refd});
      wait_ready();
      chk("host ready", 32'h1, {31'h0, dev_ready});
      chk("ready flag", 32'h1, {31'h0, ready});
      $display("test gating done");
      acc(1'h1, WEI_OFS_PWC, 32'h346);
      fire(2'h2);
      chk("lan pin", 32'h1, {31'h0, wline});
      chk("lan irq", 32'h1, {31'h0, intr});
      acc(1'h0, WEI_OFS_PWC, '0);
      chk("cause lan", 32'h2, rdv[5:4]);
      fire(2'h1);
      acc(1'h0, WEI_OFS_PWC, '0);
      chk("cause both", 32'h3, rdv[5:4]);
      chk("static pin", 32'h1, {31'h0, wline});
      acc(1'h1, WEI_OFS_PWC, 32'h376);
      acc(1'h0, WEI_OFS_PWC, '0);
      chk("cause cleared", 32'h0, rdv[5:4]);
      chk("pin off", 32'h0, {31'h0, wline});
      chk("irq off", 32'h0, {31'h0, intr});
      $display("test static done");
      acc(1'h1, WEI_OFS_PWC, 32'h146);
      ev = 2'h1;
      acc(1'h1, WEI_OFS_PWC, 32'h156);
      acc(1'h0, WEI_OFS_PWC, '0);
      chk("held cause", 32'h1, rdv[5:4]);
      ev = 2'h0;
      acc(1'h1, WEI_OFS_PWC, 32'h156);
      acc(1'h0, WEI_OFS_PWC, '0);
      chk("freed cause", 32'h0, rdv[5:4]);
      acc(1'h1, WEI_OFS_PWC, 32'h140);
      fire(2'h1);
      chk("gated irq", 32'h1, {31'h0, intr});
      chk("gated pin", 32'h1, {31'h0, wline});
      acc(1'h1, WEI_OFS_PWC, 32'h142);
      chk("low pin", 32'h0, {31'h0, wline});
      acc(1'h1, WEI_OFS_PWC, 32'h042);
      chk("enable off pin", 32'h1, {31'h0, wline});
      chk("enable off irq", 32'h0, {31'h0, intr});
      acc(1'h1, WEI_OFS_PWC, 32'h116);
      chk("od idle", 32'h1, {31'h0, wline});
      fire(2'h0);
      acc(1'h1, WEI_OFS_PWC, 32'h116);
      fire(2'h1);
      chk("od active", 32'h0, {31'h0, wline});
      acc(1'h1, WEI_OFS_PWC, 32'h11E);
      chk("od release", 32'h1, {31'h0, wline});
      $display("test polarity done");
      @(negedge i_sys_clk);
      ev = 2'h1;
      @(negedge i_sys_clk);
      ev = 2'h0;
      n = 0;
      repeat (PULSE + 10)
      begin
         @(negedge i_sys_clk);
         if (wei_if_inst.wake_line === 1'h0)
            n++;
      end
      chk("pulse length", PULSE, n);
      acc(1'h1, WEI_OFS_PWC, 32'h11E);
      $display("test pulse done");
      for (int m = 1; m < 3; m++)
      begin
         acc(1'h1, WEI_OFS_PWC, 32'h100);
         fire(2'h1);
         acc(1'h1, WEI_OFS_PWC, 32'h100 | (m << 12));
         chk("low mode", m, pstate);
         chk("ready dropped", 32'h0, {31'h0, ready});
         acc(1'h1, WEI_OFS_PWC, 32'h110);
         acc(1'h1, WEI_OFS_BYTE_TEST, 32'h0);
         wait_ready();
         chk("woken mode", 32'h0, pstate);
         chk("kept cause", 32'h1, rdv[5:4]);
         acc(1'h1, WEI_OFS_PWC, 32'h110);
      end
      acc(1'h1, WEI_OFS_PWC, 32'h3000);
      chk("reserved mode", 32'h0, pstate);
      $display("test power modes done");
      summarize();
   end
endmodule
